// ===== ai_cal_consts.vh
`ifndef AI_CAL_CONSTS_VH
`define AI_CAL_CONSTS_VH

// register group codes and byte offsets, one 32-bit word per register
`define ADDR_GRP_OFFSET 2'h0
`define ADDR_GRP_MAXCNT 2'h1
`define ADDR_GRP_CONFIG 2'h2
`define ADDR_GRP_RESULT 2'h3
`define ADDR_STATUS 6'h00
`define OFS_OFFSET_BASE 8'h00
`define OFS_MAXCNT_BASE 8'h10
`define OFS_CONFIG_BASE 8'h20
`define OFS_RESULT_BASE 8'h30
`define OFS_STATUS 8'h40

// config field positions
`define CFG_ENABLE_BIT 0
`define CFG_AVG_BIT 1
`define CFG_RANGE_LSB 2
`define CFG_RANGE_MSB 4

// range codes
`define RANGE_1_TO_5 3'h0
`define RANGE_0_TO_5 3'h1
`define RANGE_0_TO_10 3'h2
`define RANGE_PM_5 3'h3
`define RANGE_PM_10 3'h4

// reset values
`define OFFSET_RESET 16'h0000
`define MAXCNT_RESET 16'h7D00
`define CONFIG_RESET 5'h01

// accepted spans
`define OFFSET_MIN 16'hFD01
`define OFFSET_MAX 16'h02FF
`define MAXCNT_MIN 16'h7A01
`define MAXCNT_MAX 16'h7FFF

// nominal full-scale count
`define FULL_SCALE 16'h7D00

// last step of the 32-step restoring divider
`define DIV_LAST_STEP 5'h1F

`endif

// ===== ai_cal.v
`timescale 1ns/1ns
`default_nettype none
`include "ai_cal_consts.vh"

module ai_cal #(
    parameter AVG_LOG2 = 2
) (
    input wire I_CLK_SYS,
    input wire I_NRST,
    input wire [6:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [31:0] I_AVS_WRITEDATA,
    output reg [31:0] O_AVS_READDATA,
    output reg O_AVS_WAITREQUEST,
    input wire I_RAW_VALID,
    input wire [1:0] I_RAW_CHAN,
    input wire [15:0] I_RAW_DATA,
    output reg O_RAW_READY,
    output reg O_RES_VALID,
    output reg [1:0] O_RES_CHAN,
    output reg [15:0] O_RES_DATA
);

    localparam ST_IDLE = 2'b00;
    localparam ST_DIV = 2'b01;
    localparam ST_FIN = 2'b10;
    localparam ACC_W = 16 + AVG_LOG2;

    reg signed [15:0] offset [0:3];
    reg [15:0] maxcnt [0:3];
    reg [4:0] chan_cfg [0:3];
    reg [15:0] result [0:3];
    reg signed [ACC_W-1:0] acc [0:3];
    reg [AVG_LOG2-1:0] avg_cnt [0:3];

    reg [1:0] state;
    reg [1:0] cur_chan;
    reg cur_neg;
    reg [31:0] quo;
    reg [17:0] rem;
    reg [16:0] den;
    reg [4:0] step;
    reg [2:0] sample_cnt;

    // saturate signed magnitude to 16-bit two's complement
    function [15:0] sat16;
        input neg;
        input [31:0] mag;
        begin
            if (neg) begin
                if (mag >= 32'h0000_8000)
                    sat16 = 16'h8000;
                else
                    sat16 = 16'h0000 - mag[15:0];
            end else begin
                if (mag >= 32'h0000_7FFF)
                    sat16 = 16'h7FFF;
                else
                    sat16 = mag[15:0];
            end
        end
    endfunction

    // sign-extend a 16-bit count for the 17-bit difference path
    function [16:0] sext17;
        input [15:0] v;
        begin
            sext17 = {v[15], v};
        end
    endfunction

    // one restoring-division step: new partial remainder
    function [17:0] div_rem;
        input [17:0] shifted;
        input [16:0] divisor;
        begin
            if (shifted >= {1'b0, divisor})
                div_rem = shifted - {1'b0, divisor};
            else
                div_rem = shifted;
        end
    endfunction

    // span checks for parameter writes; refused values keep the old one
    function ofs_in_span;
        input [15:0] v;
        begin
            ofs_in_span = ($signed(v) >= $signed(`OFFSET_MIN))
                && ($signed(v) <= $signed(`OFFSET_MAX));
        end
    endfunction

    function max_in_span;
        input [15:0] v;
        begin
            max_in_span = (v >= `MAXCNT_MIN) && (v <= `MAXCNT_MAX);
        end
    endfunction

    function rng_in_span;
        input [2:0] code;
        begin
            rng_in_span = (code <= `RANGE_PM_10);
        end
    endfunction

    wire bus_req = (I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST;
    wire bus_wr = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    wire [1:0] bus_grp = I_AVS_ADDRESS[5:4];
    wire [1:0] bus_ch = I_AVS_ADDRESS[3:2];
    wire bus_status = ({1'b0, I_AVS_ADDRESS} == `OFS_STATUS);
    wire bus_in_map = ~I_AVS_ADDRESS[6];
    wire signed [15:0] wr_val = I_AVS_WRITEDATA[15:0];

    wire ofs_ok = ofs_in_span(I_AVS_WRITEDATA[15:0]);
    wire max_ok = max_in_span(I_AVS_WRITEDATA[15:0]);
    wire rng_ok = rng_in_span(
        I_AVS_WRITEDATA[`CFG_RANGE_MSB:`CFG_RANGE_LSB]);

    // product magnitude fits 31 bits since |raw-off| stays below 33536
    wire accept = I_RAW_VALID & O_RAW_READY;
    wire [4:0] in_cfg = chan_cfg[I_RAW_CHAN];
    wire signed [16:0] diff = $signed(sext17(I_RAW_DATA))
        - $signed(sext17(offset[I_RAW_CHAN]));
    wire signed [32:0] prod = diff * $signed({1'b0, `FULL_SCALE});
    wire [32:0] prod_mag = prod[32] ? (33'h0 - prod) : prod;
    // divisor never falls below 30466, so no divide-by-zero guard
    wire [16:0] in_den = {1'b0, maxcnt[I_RAW_CHAN]}
        - sext17(offset[I_RAW_CHAN]);

    wire [17:0] rem_sh = {rem[16:0], quo[31]};
    wire rem_ge = rem_sh >= {1'b0, den};
    wire [15:0] corr = sat16(cur_neg, quo);
    wire signed [ACC_W-1:0] acc_sum = acc[cur_chan]
        + {{AVG_LOG2{corr[15]}}, corr};
    wire signed [ACC_W-1:0] acc_mean = acc_sum >>> AVG_LOG2;
    wire cur_avg = chan_cfg[cur_chan][`CFG_AVG_BIT];
    wire avg_last = &avg_cnt[cur_chan];
    wire in_fin = (state == ST_FIN);
    // a finishing sample publishes unless it is a non-final averaged one
    wire publish = in_fin && (!cur_avg || avg_last);

    reg [31:0] next_rdata;
    integer i;
    integer j;
    integer k;

    // read word for the addressed register; unmapped words read zero
    always @* begin
        next_rdata = 32'h0000_0000;
        if (bus_status) begin
            next_rdata = {29'h0, sample_cnt};
        end else if (bus_in_map) begin
            // parameters readable for remote access
            case (bus_grp)
                `ADDR_GRP_OFFSET:
                    next_rdata = {{16{offset[bus_ch][15]}}, offset[bus_ch]};
                `ADDR_GRP_MAXCNT:
                    next_rdata = {16'h0000, maxcnt[bus_ch]};
                `ADDR_GRP_CONFIG:
                    next_rdata = {27'h0, chan_cfg[bus_ch]};
                `ADDR_GRP_RESULT:
                    next_rdata = {{16{result[bus_ch][15]}}, result[bus_ch]};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // register file with Avalon-MM slave, one wait cycle per access
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                offset[i] <= `OFFSET_RESET;
                maxcnt[i] <= `MAXCNT_RESET;
                chan_cfg[i] <= `CONFIG_RESET;
            end
        end else begin
            O_AVS_WAITREQUEST <= 1'b1;
            if (bus_req) begin
                O_AVS_WAITREQUEST <= 1'b0;
                O_AVS_READDATA <= next_rdata;
            end
            // write lands on the edge that completes the transfer
            if (bus_wr && bus_in_map && !bus_status) begin
                case (bus_grp)
                    `ADDR_GRP_OFFSET: begin
                        if (ofs_ok)
                            offset[bus_ch] <= wr_val;
                    end
                    `ADDR_GRP_MAXCNT: begin
                        if (max_ok)
                            maxcnt[bus_ch] <= I_AVS_WRITEDATA[15:0];
                    end
                    `ADDR_GRP_CONFIG: begin
                        if (rng_ok)
                            chan_cfg[bus_ch] <= I_AVS_WRITEDATA[4:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // conversion path; range code is stored only: the correction works
    // in counts, so the same span covers a different voltage per range
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            state <= ST_IDLE;
            O_RAW_READY <= 1'b1;
            cur_chan <= 2'h0;
            cur_neg <= 1'b0;
            quo <= 32'h0000_0000;
            rem <= 18'h00000;
            den <= 17'h00000;
            step <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    // disabled channel: sample consumed, nothing done
                    if (accept && in_cfg[`CFG_ENABLE_BIT]) begin
                        O_RAW_READY <= 1'b0;
                        cur_chan <= I_RAW_CHAN;
                        // line through (off,0) and (max,32000), also
                        // extended below the offset
                        cur_neg <= prod[32];
                        quo <= prod_mag[31:0];
                        // calibration captured now: a write during the
                        // division only affects the next sample
                        den <= in_den;
                        rem <= 18'h00000;
                        step <= 5'h00;
                        state <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    // restoring division, one quotient bit per cycle
                    rem <= div_rem(rem_sh, den);
                    quo <= {quo[30:0], rem_ge};
                    step <= step + 5'h01;
                    if (step == `DIV_LAST_STEP)
                        state <= ST_FIN;
                end
                ST_FIN: begin
                    // result, averaging and count blocks act on this state
                    O_RAW_READY <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    O_RAW_READY <= 1'b1;
                end
            endcase
        end
    end

    // published result and its readback copy
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RES_VALID <= 1'b0;
            O_RES_CHAN <= 2'h0;
            O_RES_DATA <= 16'h0000;
            for (k = 0; k < 4; k = k + 1) begin
                result[k] <= 16'h0000;
            end
        end else begin
            O_RES_VALID <= 1'b0;
            if (publish) begin
                // mean of 2**AVG_LOG2 corrected samples
                if (cur_avg) begin
                    result[cur_chan] <= acc_mean[15:0];
                    O_RES_DATA <= acc_mean[15:0];
                end else begin
                    result[cur_chan] <= corr;
                    O_RES_DATA <= corr;
                end
                O_RES_CHAN <= cur_chan;
                O_RES_VALID <= 1'b1;
            end
        end
    end

    // averaging sums; disabling a channel or clearing its average bit
    // restarts the mean from an empty sum
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            for (j = 0; j < 4; j = j + 1) begin
                acc[j] <= {ACC_W{1'b0}};
                avg_cnt[j] <= {AVG_LOG2{1'b0}};
            end
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (!chan_cfg[j][`CFG_ENABLE_BIT]
                    || !chan_cfg[j][`CFG_AVG_BIT]) begin
                    acc[j] <= {ACC_W{1'b0}};
                    avg_cnt[j] <= {AVG_LOG2{1'b0}};
                end
            end
            if (in_fin && cur_avg) begin
                if (avg_last) begin
                    acc[cur_chan] <= {ACC_W{1'b0}};
                    avg_cnt[cur_chan] <= {AVG_LOG2{1'b0}};
                end else begin
                    acc[cur_chan] <= acc_sum;
                    avg_cnt[cur_chan] <= avg_cnt[cur_chan]
                        + {{(AVG_LOG2-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // wrapping count of finished samples, shown in the status word
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            sample_cnt <= 3'h0;
        end else if (in_fin) begin
            sample_cnt <= sample_cnt + 3'h1;
        end
    end

endmodule // ai_cal
`default_nettype wire

// ===== ai_cal_props.sv
`timescale 1ns/1ns
`default_nettype none
module ai_cal_props (
    input wire I_CLK_SYS,
    input wire I_NRST,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [31:0] O_AVS_READDATA,
    input wire O_AVS_WAITREQUEST,
    input wire I_RAW_VALID,
    input wire O_RAW_READY,
    input wire O_RES_VALID,
    input wire [1:0] O_RES_CHAN,
    input wire [15:0] O_RES_DATA
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    wait_one_a: assert property ($fell(O_AVS_WAITREQUEST) |=>
        O_AVS_WAITREQUEST) else $error("wait low too long");
    bus_answer_a: assert property ((I_AVS_READ || I_AVS_WRITE)
        && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("bus request not answered");
    no_spurious_a: assert property (!O_AVS_WAITREQUEST |->
        $past(I_AVS_READ) || $past(I_AVS_WRITE)) else $error("stray answer");
    rdata_hold_a: assert property ($changed(O_AVS_READDATA) |->
        !O_AVS_WAITREQUEST) else $error("read data moved");
    busy_span_a: assert property ($fell(O_RAW_READY) |->
        ##32 !O_RAW_READY ##1 O_RAW_READY) else $error("busy span wrong");
    busy_start_a: assert property ($rose(O_RAW_READY) |->
        !$past(O_RAW_READY, 33) && $past(O_RAW_READY, 34))
        else $error("busy too long");
    res_ready_a: assert property (O_RES_VALID |-> O_RAW_READY
        && !$past(O_RAW_READY)) else $error("result out of step");
    res_pulse_a: assert property (O_RES_VALID |=> !O_RES_VALID)
        else $error("result pulse too long");
    res_hold_a: assert property ($changed(O_RES_DATA) ||
        $changed(O_RES_CHAN) |-> O_RES_VALID) else $error("result moved");
    cover property (O_RES_VALID);
    cover property ($fell(O_AVS_WAITREQUEST) && I_AVS_WRITE);
    cover property (I_RAW_VALID && O_RAW_READY ##1 O_RAW_READY);
endmodule // ai_cal_props
bind ai_cal ai_cal_props u_props (.I_CLK_SYS, .I_NRST, .I_AVS_READ,
    .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_RAW_VALID,
    .O_RAW_READY, .O_RES_VALID, .O_RES_CHAN, .O_RES_DATA);
`default_nettype wire

// ===== res_sink.sv
`timescale 1ns/1ns
`default_nettype none
// passive reader of published counts: no back-pressure, like the real one
module res_sink (
    input wire i_clk,
    input wire i_nrst,
    input wire i_vld,
    input wire [1:0] i_chan,
    input wire [15:0] i_data,
    output var int o_got,
    output logic [1:0] o_chan,
    output logic [15:0] o_data
);
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_got <= 0;
        end else if (i_vld) begin
            o_got <= o_got + 1;
            o_chan <= i_chan;
            o_data <= i_data;
        end
    end
endmodule // res_sink
`default_nettype wire

// ===== four_channel_analog_input_calibration_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module four_channel_analog_input_calibration_tb_top;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, vld = 0;
    logic [6:0] adr = 0;
    logic [31:0] wd = 0, rq;
    logic [1:0] ch = 0, lc;
    logic [15:0] raw = 0, ld;
    wire [31:0] rdata;
    wire waitrq, rdy, rv;
    wire [1:0] rc;
    wire [15:0] rdat;
    int failures = 0, checks_done = 0, got, i;
    int off[4], mx[4], cfg[4], acc[4], cnt[4];
    ai_cal #(.AVG_LOG2(2)) dut (.I_CLK_SYS(clk), .I_NRST(nrst),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitrq), .I_RAW_VALID(vld), .I_RAW_CHAN(ch),
        .I_RAW_DATA(raw), .O_RAW_READY(rdy), .O_RES_VALID(rv),
        .O_RES_CHAN(rc), .O_RES_DATA(rdat));
    res_sink sink (.i_clk(clk), .i_nrst(nrst), .i_vld(rv), .i_chan(rc),
        .i_data(rdat), .o_got(got), .o_chan(lc), .o_data(ld));
    initial forever #4 clk = ~clk;
    task conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d; n = 0;
        do begin @(posedge clk); n++; end while (waitrq !== 1'b0 && n < 20);
        rq = rdata;
        rd <= 0; wr <= 0;
        if (n >= 20) begin failures++; conclude; end
    endtask
    function int mval(input logic [6:0] a);
        case (a[6:4])
            0: return off[a[3:2]];
            1: return mx[a[3:2]];
            2: return cfg[a[3:2]];
            default: return 0;
        endcase
    endfunction
    task rchk(input logic [6:0] a);
        bus(0, a, 0);
        chk(rq, mval(a));
    endtask
    task wchk(input logic [6:0] a, input logic [31:0] d);
        int v;
        v = $signed(d[15:0]);
        bus(1, a, d);
        case (a[6:4])
            0: if (v >= -767 && v <= 767) off[a[3:2]] = v;
            1: if (v >= 'h7A01 && v <= 'h7FFF) mx[a[3:2]] = v;
            2: if (d[4:2] <= 4) begin
                cfg[a[3:2]] = d[4:0];
                acc[a[3:2]] = 0;
                cnt[a[3:2]] = 0;
            end
        endcase
        rchk(a);
    endtask
    function int corr(input int c, input int r);
        int q;
        q = (r - off[c]) * 32000 / (mx[c] - off[c]);
        return q > 32767 ? 32767 : (q < -32768 ? -32768 : q);
    endfunction
    task smp(input int c, input int r);
        int n, g, e;
        bit p;
        g = got; e = corr(c, r); p = cfg[c][0];
        if (p && cfg[c][1]) begin
            acc[c] += e; cnt[c]++;
            p = cnt[c] == 4; e = acc[c] >>> 2;
            if (p) begin acc[c] = 0; cnt[c] = 0; end
        end
        @(posedge clk);
        vld <= 1; ch <= c[1:0]; raw <= r[15:0]; n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
        vld <= 0; n = 0;
        while (got == g && n < 60) begin @(posedge clk); n++; end
        if (p && got == g) begin failures++; conclude; end
        if (p) chk($signed(ld), e);
        if (p) chk(lc, c);
        else chk(got, g);
    endtask
    initial begin
        void'($urandom(32'h4D96));
        for (i = 0; i < 4; i++) begin
            off[i] = 0; mx[i] = 'h7D00; cfg[i] = 1; acc[i] = 0; cnt[i] = 0;
        end
        repeat (16) @(posedge clk);
        nrst <= 1;
        for (i = 0; i < 12; i++) rchk(7'(i * 4));
        rchk(7'h40);
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            wchk(7'h04, i[1] ? (i[0] ? 'h2FF : 'h300) : 'hFD00 + i);
            wchk(7'h14, i[1] ? 'h7FFF + i[0] : 'h7A00 + i);
        end
        for (i = 0; i < 6; i++) wchk(7'h28, i * 4 + 1);
        $display("test limits done");
        repeat (6) smp(0, int'($urandom_range(65535)) - 32768);
        wchk(7'h08, 64);
        wchk(7'h18, 32576);
        smp(2, 64);
        smp(2, 32576);
        smp(2, -32448);
        smp(3, -32448);
        wchk(7'h04, 'hFD01);
        wchk(7'h14, 'h7A01);
        smp(1, 32767);
        $display("test correction done");
        wchk(7'h2C, 0);
        smp(3, 100);
        wchk(7'h2C, 3);
        repeat (4) smp(3, int'($urandom_range(4000)) - 2000);
        $display("test enable and averaging done");
        conclude;
    end
endmodule // four_channel_analog_input_calibration_tb_top
`default_nettype wire
